// File: shared/ioacc_defs.vh
// Constants of the command executor: codes, banks, ports, operations, frame layout
`ifndef IOACC_DEFS_VH
`define IOACC_DEFS_VH
`define IOACC_INS_WRITE_OUT   8'h0e
`define IOACC_INS_READ_IO     8'h0f
`define IOACC_INS_ARITH       8'h13
`define IOACC_INS_COMPARE     8'h14
`define IOACC_INS_COND_JUMP   8'h15
`define IOACC_BANK_DIN        8'h00
`define IOACC_BANK_AIN        8'h01
`define IOACC_BANK_DOUT       8'h02
`define IOACC_PORT_ALL        8'hff
`define IOACC_PORT_VSUPPLY    8'h08
`define IOACC_PORT_ADC0       8'h00
`define IOACC_NUM_IN          4
`define IOACC_NUM_OUT         2
`define IOACC_OP_ADD          8'h00
`define IOACC_OP_SUB          8'h01
`define IOACC_OP_MUL          8'h02
`define IOACC_OP_DIV          8'h03
`define IOACC_OP_MOD          8'h04
`define IOACC_OP_AND          8'h05
`define IOACC_OP_OR           8'h06
`define IOACC_OP_XOR          8'h07
`define IOACC_OP_NOT          8'h08
`define IOACC_OP_LOAD         8'h09
`define IOACC_CC_ZERO         8'h00
`define IOACC_CC_NZERO        8'h01
`define IOACC_CC_EQ           8'h02
`define IOACC_CC_NE           8'h03
`define IOACC_CC_GT           8'h04
`define IOACC_CC_GE           8'h05
`define IOACC_CC_LT           8'h06
`define IOACC_CC_LE           8'h07
`define IOACC_ST_OK           8'h64
`define IOACC_ST_BAD_TYPE     8'h03
`define IOACC_ST_BAD_VALUE    8'h04
`define IOACC_ST_BAD_CMD      8'h02
`define IOACC_ST_BAD_SUM      8'h01
`define IOACC_FRAME_LEN       4'h9
`define IOACC_ADC_W           12
`define IOACC_VOLT_W          16
`define IOACC_ACC_RST         32'h00000000
`define IOACC_HOST_ADDR_RST   8'h02
`define IOACC_OWN_ADDR_RST    8'h01
`endif

// File: logic/ioacc_frame_tx.v
// Serialiser of a nine byte reply frame with running checksum
`timescale 1ns/1ns
`include "ioacc_defs.vh"
module ioacc_frame_tx (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [63:0] body,
  output wire        busy,
  output reg  [7:0]  txData,
  output wire        txValid,
  input  wire        txReady
);
  reg  [63:0] shift_r;   // Bytes still to send, first in top byte
  reg  [3:0]  count_r;   // Bytes left in frame
  reg  [7:0]  sum_r;     // Running checksum
  reg         valid_r;   // A byte is offered

  assign busy    = valid_r;
  assign txValid = valid_r;

  // Load, shift on each accepted byte, end with checksum
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 64'h0;
      count_r <= 4'h0;
      sum_r   <= 8'h00;
      valid_r <= 1'b0;
      txData  <= 8'h00;
    end else if (start && !valid_r) begin
      shift_r <= {body[55:0], 8'h00};
      txData  <= body[63:56];
      sum_r   <= body[63:56];
      count_r <= `IOACC_FRAME_LEN - 4'h1;
      valid_r <= 1'b1;
    end else if (valid_r && txReady) begin
      if (count_r == 4'h0) begin
        valid_r <= 1'b0;
      end else if (count_r == 4'h1) begin
        txData  <= sum_r;
        count_r <= 4'h0;
      end else begin
        txData  <= shift_r[63:56];
        sum_r   <= sum_r + shift_r[63:56];
        shift_r <= {shift_r[55:0], 8'h00};
        count_r <= count_r - 4'h1;
      end
    end
  end
endmodule

// File: logic/ioacc_exec.v
// Executor for input read, accumulator arithmetic and compare commands
// Operation
// - Read instruction: type=port, bank 0..2
// - Digital gives 0/1, ADC 0..4095
// - Program mode copies sample to accumulator
// - Direct mode leaves accumulator alone
// - Direct read replies status 100, value
// - Bank 0 ports 0..3 digital inputs
// - Port 255 packs inputs into accumulator
// - Bank 1: port 0 ADC, 8 supply
// - Analog lines readable both ways
// - Bank 2 returns driven output levels
// - Arithmetic instruction: ten operations by type
// - Result of accumulator and operand stored
// - Direct arithmetic replies 100 with operand
// - Compare sets flags, accumulator unchanged
// - Conditional jump tests eight flag conditions
// - Output write drives output lines
`timescale 1ns/1ns
`include "ioacc_defs.vh"
module ioacc_exec (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire [7:0]               rxData,
  input  wire                     rxValid,
  output wire                     rxReady,
  output wire [7:0]               txData,
  output wire                     txValid,
  input  wire                     txReady,
  input  wire                     progStep,
  input  wire [7:0]               progIns,
  input  wire [7:0]               progType,
  input  wire [7:0]               progBank,
  input  wire [31:0]              progValue,
  output wire                     progReady,
  output reg                      jumpTaken,
  output reg  [31:0]              jumpTarget,
  input  wire [`IOACC_NUM_IN-1:0] inPin,
  input  wire [`IOACC_ADC_W-1:0]  adcValue,
  input  wire [`IOACC_VOLT_W-1:0] supplyTenths,
  output reg  [`IOACC_NUM_OUT-1:0] outLine,
  output reg  [31:0]              accValue,
  output reg                      flagZero,
  output reg                      flagNeg,
  output reg                      flagEq,
  output reg                      flagGt
);
  localparam ST_RECV = 3'b001;   // Collecting command bytes
  localparam ST_EXEC = 3'b010;   // Executing decoded command
  localparam ST_SEND = 3'b100;   // Waiting for reply to go out

  reg  [2:0]  state_r;           // One-hot state
  reg  [3:0]  rxCount_r;         // Bytes received in frame
  reg  [7:0]  rxSum_r;           // Running checksum of frame
  reg  [63:0] cmd_r;             // First eight command bytes
  reg         sumOk_r;           // Checksum matched
  reg  [`IOACC_NUM_IN-1:0] inMeta_r;  // Input sync stage 1
  reg  [`IOACC_NUM_IN-1:0] inSync_r;  // Input sync stage 2
  reg         txStart_r;         // Pulse to start reply
  reg  [63:0] txBody_r;          // Reply frame body
  wire        txBusy;            // Reply sender busy

  // Command fields
  wire [7:0]  cmdAddr  = cmd_r[63:56];
  wire [7:0]  cmdIns   = cmd_r[55:48];
  wire [7:0]  cmdType  = cmd_r[47:40];
  wire [7:0]  cmdBank  = cmd_r[39:32];
  wire [31:0] cmdValue = cmd_r[31:0];

  // Synchronise the input pins, two stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inMeta_r <= {`IOACC_NUM_IN{1'b0}};
      inSync_r <= {`IOACC_NUM_IN{1'b0}};
    end else begin
      inMeta_r <= inPin;
      inSync_r <= inMeta_r;
    end
  end

  // Input sample mux by bank and port
  reg  [31:0] sample;    // Sampled value
  reg         sampleOk;  // Port and bank valid
  reg  [31:0] accPack;   // Packed inputs for port 255
  function [31:0] read_port;
    input [7:0] bank;
    input [7:0] port;
    input [`IOACC_NUM_IN-1:0] ins;
    input [`IOACC_NUM_OUT-1:0] outs;
    input [`IOACC_ADC_W-1:0] adc;
    input [`IOACC_VOLT_W-1:0] volt;
    begin
      read_port = 32'h0;
      case (bank)
        `IOACC_BANK_DIN: begin
          if (port == `IOACC_PORT_ALL) begin
            read_port = {{(32-`IOACC_NUM_IN){1'b0}}, ins};
          end else if (port < `IOACC_NUM_IN) begin
            read_port = {31'h0, ins[port[1:0]]};
          end
        end
        `IOACC_BANK_AIN: begin
          if (port == `IOACC_PORT_ADC0) begin
            read_port = {{(32-`IOACC_ADC_W){1'b0}}, adc};
          end else if (port == `IOACC_PORT_VSUPPLY) begin
            read_port = {{(32-`IOACC_VOLT_W){1'b0}}, volt};
          end
        end
        `IOACC_BANK_DOUT: begin
          if (port < `IOACC_NUM_OUT) begin
            read_port = {31'h0, outs[port[0]]};
          end
        end
        default: begin
          read_port = 32'h0;
        end
      endcase
    end
  endfunction

  // Operand sources: program on a program step, frame otherwise
  wire        isProg   = (state_r == ST_RECV) && progStep && !txBusy;
  wire [7:0]  exIns    = isProg ? progIns   : cmdIns;
  wire [7:0]  exType   = isProg ? progType  : cmdType;
  wire [7:0]  exBank   = isProg ? progBank  : cmdBank;
  wire [31:0] exValue  = isProg ? progValue : cmdValue;
  wire        exDirect = (state_r == ST_EXEC);

  // Validity and sample computed once per command
  always @* begin
    // bank 0 reads the digital inputs, bank 1 the ADC and supply, bank 2 the output lines
    sample   = read_port(exBank, exType, inSync_r, outLine, adcValue, supplyTenths);
    accPack  = {24'h0, {(8-`IOACC_NUM_IN){1'b0}}, inSync_r};
    sampleOk = 1'b0;
    case (exBank)
      `IOACC_BANK_DIN:  sampleOk = (exType < `IOACC_NUM_IN) || (exType == `IOACC_PORT_ALL);
      `IOACC_BANK_AIN:  sampleOk = (exType == `IOACC_PORT_ADC0) ||
                                   (exType == `IOACC_PORT_VSUPPLY);
      `IOACC_BANK_DOUT: sampleOk = (exType < `IOACC_NUM_OUT);
      default:          sampleOk = 1'b0;
    endcase
  end

  // Accumulator arithmetic, signed operand
  reg  [31:0] arith;     // Arithmetic result
  reg         arithOk;   // Operation valid
  wire signed [31:0] sAcc = accValue;
  wire signed [31:0] sOp  = exValue;
  wire signed [63:0] prod = sAcc * sOp;
  always @* begin
    arith   = accValue;
    arithOk = 1'b1;
    case (exType)
      `IOACC_OP_ADD:  arith = accValue + exValue;
      `IOACC_OP_SUB:  arith = accValue - exValue;
      `IOACC_OP_MUL:  arith = prod[31:0];
      `IOACC_OP_DIV:  begin
        arithOk = (exValue != 32'h0);
        arith   = arithOk ? $unsigned(sAcc / sOp) : accValue;
      end
      `IOACC_OP_MOD:  begin
        arithOk = (exValue != 32'h0);
        arith   = arithOk ? $unsigned(sAcc % sOp) : accValue;
      end
      `IOACC_OP_AND:  arith = accValue & exValue;
      `IOACC_OP_OR:   arith = accValue | exValue;
      `IOACC_OP_XOR:  arith = accValue ^ exValue;
      `IOACC_OP_NOT:  arith = ~accValue;
      `IOACC_OP_LOAD: arith = exValue;
      default: begin
        arith   = accValue;
        arithOk = 1'b0;
      end
    endcase
  end

  // Jump condition from compare flags
  reg condMet;   // Selected condition true
  always @* begin
    case (exType)
      `IOACC_CC_ZERO:  condMet = flagZero;
      `IOACC_CC_NZERO: condMet = !flagZero;
      `IOACC_CC_EQ:    condMet = flagEq;
      `IOACC_CC_NE:    condMet = !flagEq;
      `IOACC_CC_GT:    condMet = flagGt;
      `IOACC_CC_GE:    condMet = flagGt || flagEq;
      `IOACC_CC_LT:    condMet = flagNeg;
      `IOACC_CC_LE:    condMet = flagNeg || flagEq;
      default:         condMet = 1'b0;
    endcase
  end

  wire execNow = isProg || exDirect;
  wire [31:0] diff = accValue - exValue;

  assign rxReady   = (state_r == ST_RECV);
  assign progReady = (state_r == ST_RECV) && !txBusy;

  // Frame receiver, executor and reply builder
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_RECV;
      rxCount_r  <= 4'h0;
      rxSum_r    <= 8'h00;
      cmd_r      <= 64'h0;
      sumOk_r    <= 1'b0;
      txStart_r  <= 1'b0;
      txBody_r   <= 64'h0;
      accValue   <= `IOACC_ACC_RST;
      outLine    <= {`IOACC_NUM_OUT{1'b0}};
      flagZero   <= 1'b0;
      flagNeg    <= 1'b0;
      flagEq     <= 1'b0;
      flagGt     <= 1'b0;
      jumpTaken  <= 1'b0;
      jumpTarget <= 32'h0;
    end else begin
      txStart_r <= 1'b0;
      jumpTaken <= 1'b0;
      case (state_r)
        ST_RECV: begin
          if (rxValid) begin
            if (rxCount_r == `IOACC_FRAME_LEN - 4'h1) begin
              sumOk_r   <= (rxData == rxSum_r);
              rxCount_r <= 4'h0;
              rxSum_r   <= 8'h00;
              state_r   <= ST_EXEC;
            end else begin
              cmd_r     <= {cmd_r[55:0], rxData};
              rxSum_r   <= rxSum_r + rxData;
              rxCount_r <= rxCount_r + 4'h1;
            end
          end
        end
        ST_EXEC: begin
          state_r <= ST_SEND;
        end
        ST_SEND: begin
          if (!txBusy && !txStart_r) begin
            state_r <= ST_RECV;
          end
        end
        default: begin
          state_r <= ST_RECV;
        end
      endcase

      // Command effects; direct commands need good checksum
      if (execNow && (isProg || sumOk_r)) begin
        case (exIns)
          `IOACC_INS_READ_IO: begin
            if (isProg && sampleOk) begin
              accValue <= (exBank == `IOACC_BANK_DIN && exType == `IOACC_PORT_ALL) ?
                          accPack : sample;
            end
          end
          `IOACC_INS_ARITH: begin
            if (arithOk) begin
              accValue <= arith;
            end
          end
          `IOACC_INS_COMPARE: begin
            flagEq   <= (accValue == exValue);
            flagZero <= (diff == 32'h0);
            flagGt   <= (sAcc > sOp);
            flagNeg  <= (sAcc < sOp);
          end
          `IOACC_INS_WRITE_OUT: begin
            if (exBank == `IOACC_BANK_DOUT && exType < `IOACC_NUM_OUT) begin
              outLine[exType[0]] <= exValue[0];
            end else if (exBank == `IOACC_BANK_DOUT && exType == `IOACC_PORT_ALL) begin
              outLine <= (exValue == 32'hffffffff) ? accValue[`IOACC_NUM_OUT-1:0] :
                                                     exValue[`IOACC_NUM_OUT-1:0];
            end
          end
          `IOACC_INS_COND_JUMP: begin
            if (isProg && condMet) begin
              jumpTaken  <= 1'b1;
              jumpTarget <= exValue;
            end
          end
          default: begin
            jumpTaken <= 1'b0;
          end
        endcase
      end

      // Reply in direct mode only
      if (exDirect) begin
        txStart_r <= 1'b1;
        txBody_r[63:56] <= `IOACC_HOST_ADDR_RST;
        txBody_r[55:48] <= cmdAddr;
        txBody_r[39:32] <= cmdIns;
        txBody_r[31:0]  <= 32'h0;
        if (!sumOk_r) begin
          txBody_r[47:40] <= `IOACC_ST_BAD_SUM;
        end else begin
          case (cmdIns)
            `IOACC_INS_READ_IO: begin
              txBody_r[47:40] <= sampleOk ? `IOACC_ST_OK : `IOACC_ST_BAD_TYPE;
              txBody_r[31:0]  <= (cmdBank == `IOACC_BANK_DIN && cmdType == `IOACC_PORT_ALL) ?
                                 accPack : sample;
            end
            `IOACC_INS_ARITH: begin
              txBody_r[47:40] <= arithOk ? `IOACC_ST_OK : `IOACC_ST_BAD_VALUE;
              txBody_r[31:0]  <= cmdValue;
            end
            `IOACC_INS_COMPARE, `IOACC_INS_WRITE_OUT, `IOACC_INS_COND_JUMP: begin
              txBody_r[47:40] <= `IOACC_ST_OK;
            end
            default: begin
              txBody_r[47:40] <= `IOACC_ST_BAD_CMD;
            end
          endcase
        end
      end
    end
  end

  // Reply serialiser
  ioacc_frame_tx uTx (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (txStart_r),
    .body    (txBody_r),
    .busy    (txBusy),
    .txData  (txData),
    .txValid (txValid),
    .txReady (txReady)
  );
endmodule

// File: test/ioacc_exec_asserts.sv
// Concurrent checks on the command executor ports
`timescale 1ns/1ns
`include "ioacc_defs.vh"
module ioacc_exec_asserts (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     rxReady,
  input wire logic [7:0]               txData,
  input wire logic                     txValid,
  input wire logic                     txReady,
  input wire logic                     progStep,
  input wire logic [7:0]               progIns,
  input wire logic [7:0]               progType,
  input wire logic [7:0]               progBank,
  input wire logic [31:0]              progValue,
  input wire logic                     progReady,
  input wire logic                     jumpTaken,
  input wire logic [`IOACC_ADC_W-1:0]  adcValue,
  input wire logic [31:0]              accValue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic jumpReq_r;  // Jump step taken last edge
  logic accCause_r; // Accumulator may change now
  // Remember what may cause jumps and accumulator updates
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jumpReq_r  <= 1'b0;
      accCause_r <= 1'b0;
    end else begin
      jumpReq_r  <= progStep && progReady && progIns == `IOACC_INS_COND_JUMP;
      accCause_r <= (progStep && progReady) || (!rxReady && !txValid);
    end
  end
  sequence sProg(logic [7:0] ins);
    progStep && progReady && progIns == ins;
  endsequence
  a_prog_adc: assert property (sProg(`IOACC_INS_READ_IO) ##0 (progType == 8'h00 &&
    progBank == 8'h01) |=> accValue == {20'h0, $past(adcValue)}) else $error("adc copy");
  a_prog_load: assert property (sProg(`IOACC_INS_ARITH) ##0 (progType == 8'h09)
    |=> accValue == $past(progValue)) else $error("load operand");
  a_cmp_keep: assert property (sProg(`IOACC_INS_COMPARE) |=> $stable(accValue))
    else $error("compare changed accumulator");
  a_jump_cause: assert property (jumpTaken |-> jumpReq_r)
    else $error("jump without jump step");
  a_acc_cause: assert property ($changed(accValue) |-> accCause_r)
    else $error("accumulator changed without command");
  a_reply_first: assert property ($rose(txValid) |-> txData == 8'h02)
    else $error("reply does not open with host address");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte dropped while stalled");
  a_rx_closed: assert property (txValid |-> !rxReady && !progReady)
    else $error("accepting while replying");
  a_reply_due: assert property ($fell(rxReady) |-> ##[1:3] txValid)
    else $error("reply late");
endmodule
bind ioacc_exec ioacc_exec_asserts u_chk (.clk(clk), .rst_n(rst_n), .rxReady(rxReady),
  .txData(txData), .txValid(txValid), .txReady(txReady), .progStep(progStep),
  .progIns(progIns), .progType(progType), .progBank(progBank), .progValue(progValue),
  .progReady(progReady), .jumpTaken(jumpTaken), .adcValue(adcValue), .accValue(accValue));

// File: test/ioacc_host_model.sv
// Host model: sends command frames and collects reply frames
`timescale 1ns/1ns
module ioacc_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  output logic      [7:0] rxData,
  output logic            rxValid,
  input  wire logic       rxReady,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady
);
  logic [7:0] rep [9]; // Last reply frame
  initial begin
    rxData  = 8'h00;
    rxValid = 1'b0;
  end
  // Reply sink, stalls every other cycle when slow
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) txReady <= 1'b0;
    else txReady <= slow ? ~txReady : 1'b1;
  end
  task automatic xfer(input logic [63:0] body, input logic badSum);
    logic [7:0] sum;
    logic [7:0] b;
    logic       ok;
    int         k;
    sum = 8'h00;
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      b = (i < 8) ? body[63-8*i -: 8] : sum ^ {7'h0, badSum};
      sum = sum + b;
      rxValid <= 1'b1;
      rxData  <= b;
      do begin
        @(negedge clk);
        ok = rxReady;
        @(posedge clk);
      end while (!ok);
    end
    rxValid <= 1'b0;
    rxData  <= ~b;
    k = 0;
    while (k < 9) begin
      @(negedge clk);
      if (txValid && txReady) begin
        rep[k] = txData;
        k++;
      end
    end
  endtask
endmodule

// File: test/test_io_read_and_accumulator_ops.sv
// Testbench of the command executor
`timescale 1ns/1ns
`include "ioacc_defs.vh"
module test_io_read_and_accumulator_ops;
  logic clk, rst_n, slow, rxValid, rxReady, txValid, txReady, progStep, progReady;
  logic [7:0]  rxData, txData, progIns, progType, progBank;
  logic [31:0] progValue, jumpTarget, accValue;
  logic        jumpTaken, flagZero, flagNeg, flagEq, flagGt;
  logic [3:0]  inPin;
  logic [11:0] adcValue;
  logic [15:0] supplyTenths;
  logic [1:0]  outLine;
  int          errors, nChecks;
  ioacc_exec dut (.clk(clk), .rst_n(rst_n), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
    .progStep(progStep), .progIns(progIns), .progType(progType), .progBank(progBank),
    .progValue(progValue), .progReady(progReady), .jumpTaken(jumpTaken),
    .jumpTarget(jumpTarget), .inPin(inPin), .adcValue(adcValue),
    .supplyTenths(supplyTenths), .outLine(outLine), .accValue(accValue),
    .flagZero(flagZero), .flagNeg(flagNeg), .flagEq(flagEq), .flagGt(flagGt));
  ioacc_host_model host (.clk(clk), .rst_n(rst_n), .slow(slow), .rxData(rxData),
    .rxValid(rxValid), .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txReady(txReady));
  task automatic finish_test();
    if (errors == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] rb(int k);
    return {24'h0, host.rep[k]};
  endfunction
  // Direct command; mode bit 0 corrupts checksum, bit 1 skips value
  task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] val,
                     input logic [7:0] st, input logic [31:0] expVal, input logic [1:0] mode);
    logic [7:0] s;
    host.xfer({8'h01, ins, typ, bnk, val}, mode[0]);
    s = 8'h00;
    for (int k = 0; k < 8; k++) s = s + host.rep[k];
    check("host addr", 32'h02, rb(0));
    check("target", 32'h01, rb(1));
    check("status", {24'h0, st}, rb(2));
    check("ins echo", {24'h0, ins}, rb(3));
    check("checksum", {24'h0, s}, rb(8));
    if (!mode[1]) check("value", expVal, {rb(4)<<24 | rb(5)<<16 | rb(6)<<8 | rb(7)});
  endtask
  // Program step, held until taken at an edge with progReady high
  task automatic pstep(input logic [7:0] ins, typ, input logic [31:0] val);
    logic ok;
    @(posedge clk);
    progStep  <= 1'b1;
    progIns   <= ins;
    progType  <= typ;
    progBank  <= typ == 8'hff ? 8'h00 : 8'h01;
    progValue <= val;
    do begin
      @(negedge clk);
      ok = progReady;
      @(posedge clk);
    end while (!ok);
    progStep <= 1'b0;
    #1;
  endtask
  // Reads of all banks in direct mode
  task automatic t_direct_read();
    logic [31:0] acc;
    acc = accValue;
    for (int p = 0; p < 4; p++) cmd(8'h0f, p, 8'h00, 0, 8'h64, {31'h0, inPin[p]}, 2'b00);
    cmd(8'h0f, 8'hff, 8'h00, 0, 8'h64, {28'h0, inPin}, 2'b00);
    cmd(8'h0f, 8'h00, 8'h01, 0, 8'h64, {20'h0, adcValue}, 2'b00);
    cmd(8'h0f, 8'h08, 8'h01, 0, 8'h64, {16'h0, supplyTenths}, 2'b00);
    cmd(8'h0f, 8'h00, 8'h03, 0, 8'h03, 0, 2'b10);
    check("acc kept", acc, accValue);
    for (int v = 1; v < 3; v++) begin
      cmd(8'h0e, 8'h00, 8'h02, v & 1, 8'h64, 0, 2'b10);
      cmd(8'h0e, 8'h01, 8'h02, v >> 1, 8'h64, 0, 2'b10);
      check("outLine", v, {30'h0, outLine});
      cmd(8'h0f, 8'h00, 8'h02, 0, 8'h64, v & 1, 2'b00);
      cmd(8'h0f, 8'h01, 8'h02, 0, 8'h64, v >> 1, 2'b00);
    end
  endtask
  // Ten operations through the program port, then direct arithmetic
  task automatic t_arith();
    logic [7:0]  ops [10] = '{9, 0, 1, 2, 3, 4, 6, 5, 7, 8};
    logic [31:0] opd [10] = '{100, 23, 3, 3, 7, 10, 32'hf0, 32'h3c, 32'hff, 0};
    logic [31:0] e;
    pstep(8'h0f, 8'h00, 0);
    check("acc adc", {20'h0, adcValue}, accValue);
    pstep(8'h0f, 8'hff, 0);
    check("acc inputs", {28'h0, inPin}, accValue & 32'hff);
    e = 0;
    for (int i = 0; i < 10; i++) begin
      case (ops[i])
        0: e = e + opd[i];
        1: e = e - opd[i];
        2: e = e * opd[i];
        3: e = e / opd[i];
        4: e = e % opd[i];
        5: e = e & opd[i];
        6: e = e | opd[i];
        7: e = e ^ opd[i];
        8: e = ~e;
        default: e = opd[i];
      endcase
      pstep(8'h13, ops[i], opd[i]);
      check("acc arith", e, accValue);
    end
    cmd(8'h13, 8'h09, 8'h00, 32'hfffeec78, 8'h64, 32'hfffeec78, 2'b00);
    check("acc load", 32'hfffeec78, accValue);
    cmd(8'h13, 8'h03, 8'h00, 0, 8'h04, 0, 2'b10);
    cmd(8'h13, 8'h09, 8'h00, 5, 8'h01, 0, 2'b11);
    check("acc refused", 32'hfffeec78, accValue);
    cmd(8'h13, 8'h03, 8'h00, 32'hfffffffb, 8'h64, 32'hfffffffb, 2'b00);
    check("acc signed div", 32'h0000371b, accValue);
  endtask
  // Compare then every jump condition, equal, lower and greater cases
  task automatic t_compare_jump();
    logic [7:0]  mask [3] = '{8'ha5, 8'hca, 8'h3a};
    logic [3:0]  flg [3] = '{4'hc, 4'h1, 4'h2};
    logic [31:0] cmpv [3] = '{5, 7, 32'hfffffffd};
    pstep(8'h13, 8'h09, 5);
    for (int r = 0; r < 3; r++) begin
      pstep(8'h14, 8'h00, cmpv[r]);
      check("acc compare", 5, accValue);
      check("flags", flg[r], {flagZero, flagEq, flagGt, flagNeg});
      for (int c = 0; c < 8; c++) begin
        pstep(8'h15, c, 32'h40 + c);
        check("jump", mask[r][c], jumpTaken);
        if (mask[r][c]) check("target", 32'h40 + c, jumpTarget);
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {rst_n, slow, progStep, progIns, progType, progBank, progValue} = '0;
    inPin = 4'ha;
    adcValue = 12'hfff;
    supplyTenths = 16'h00f0;
    errors = 0;
    nChecks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_direct_read();
    slow <= 1'b1;
    inPin <= 4'h5;
    adcValue <= 12'h12e;
    repeat (4) @(posedge clk);
    t_direct_read();
    t_arith();
    t_compare_jump();
    finish_test();
  end
endmodule
